// ===== design/wrsag_pkg.sv
// Constants, types and encodings for the working register and stack address generator
// How it works
// [RULE1] Short operand bit 3 selects slice pointer zero or one.
// [RULE2] Upper five pointer bits become upper five address bits, one 8-byte slice.
// [RULE3] Operand bits 2 to 0 become the low three address bits.
// [RULE4] Byte operand with upper nibble 1100B resolves like a short working operand.
// [RULE5] In byte working addressing bit 3 picks the pointer, bits 2-0 low bits.
// [RULE6] Call pushes program counter; subroutine exit pops it back.
// [RULE7] Interrupt entry pushes program counter and flags; interrupt exit pops both.
// [RULE8] Stack pointer decrements before each push, increments after each pop.
// [RULE9] Stack pointer high byte lives at D8H, low byte at D9H.
// [RULE10] Stack pointer has no reset value; undefined until software writes it.
// [RULE11] Stack pointer steps as a full 16-bit word, carries reach high byte.
// [RULE12] Software should start the low byte at FFH to spare the high byte.
// [RULE13] Register mode returns the named register or pair contents as operand.
// [RULE14] Indirect register mode uses register or pair contents as the address.
// [RULE15] Indirect register addressing never reaches set-1 locations C0H to FFH.
// [RULE16] Seven addressing modes exist; this block resolves the register-based ones.
// [RULE17] After reset pointers select C0H-C7H and C8H-CFH.
// [RULE18] Register pair: even address holds MSB, next odd holds LSB.
package wrsag_pkg;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WRSAG_SP_HI_ADDR = 8'hd8;
  localparam logic [7:0] WRSAG_SP_LO_ADDR = 8'hd9;
  localparam logic [7:0] WRSAG_SP0_ADDR   = 8'hd6;
  localparam logic [7:0] WRSAG_SP1_ADDR   = 8'hd7;
  localparam logic [7:0] WRSAG_SP0_RST    = 8'hc0;
  localparam logic [7:0] WRSAG_SP1_RST    = 8'hc8;
  localparam logic [3:0] WRSAG_WORK_NIB   = 4'hc;
  localparam logic [1:0] WRSAG_SET1_TOP   = 2'h3;
  localparam int         WRSAG_SEL_BIT    = 3;

  // ----------------------------------------------------------------
  // Modes and stack commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WRSAG_M_REG   = 3'h0,
    WRSAG_M_IREG  = 3'h1,
    WRSAG_M_IDX   = 3'h2,
    WRSAG_M_DA    = 3'h3,
    WRSAG_M_IA    = 3'h4,
    WRSAG_M_RA    = 3'h5,
    WRSAG_M_IM    = 3'h6
  } wrsag_mode_e;

  typedef enum logic [2:0] {
    WRSAG_C_NONE  = 3'h0,
    WRSAG_C_PUSH  = 3'h1,
    WRSAG_C_POP   = 3'h2,
    WRSAG_C_CALL  = 3'h3,
    WRSAG_C_SUB_EXIT = 3'h4,
    WRSAG_C_INT      = 3'h5,
    WRSAG_C_INT_EXIT = 3'h6
  } wrsag_cmd_e;

  // Stack sequencer: Gray codes along idle, byte 0, byte 1, byte 2
  typedef enum logic [1:0] {
    WRSAG_S_IDLE  = 2'b00,
    WRSAG_S_B0    = 2'b01,
    WRSAG_S_B1    = 2'b11,
    WRSAG_S_B2    = 2'b10
  } wrsag_state_e;

  // Operand request from the sequencer
  typedef struct packed {
    logic        valid;
    wrsag_mode_e mode;
    logic        short_op;
    logic        pair;
    logic [7:0]  field;
  } wrsag_opreq_s;

  // Register file access issued by the block
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wrsag_rfreq_s;
endpackage

// ===== design/wrsag_core.sv
// Working register address generation and system stack pointer sequencer
`timescale 1ns/100ps
module wrsag_core
  import wrsag_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire wrsag_opreq_s op_req,
  input  wire logic         sp_lo_set,
  input  wire logic         sp_hi_set,
  input  wire logic [7:0]   sp_set_data,
  input  wire logic         ptr_set,
  input  wire logic [7:0]   ptr_set_data,
  input  wire logic         ptr_set_sel,
  input  wire wrsag_cmd_e   stk_cmd,
  input  wire logic [15:0]  stk_pc,
  input  wire logic [7:0]   stk_flags,
  input  wire logic [7:0]   stk_data,
  input  wire logic [7:0]   rf_rdata,
  output wrsag_rfreq_s      rf_req_r,
  output logic              op_done_r,
  output logic [15:0]       op_addr_r,
  output logic [15:0]       op_value_r,
  output logic              op_reject_r,
  output logic              stk_busy_r,
  output logic              stk_done_r,
  output logic [15:0]       pc_out_r,
  output logic [7:0]        flags_out_r,
  output logic [7:0]        pop_data_r,
  output logic [15:0]       stack_pointer_word_r,
  output logic [7:0]        slice_pointer_zero_r,
  output logic [7:0]        slice_pointer_one_r
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Working register resolution, shared by the short and byte forms
  function automatic logic [7:0] work_addr(input logic [3:0] nib,
                                           input logic [7:0] p0,
                                           input logic [7:0] p1);
    logic [7:0] p;
    p = nib[WRSAG_SEL_BIT] ? p1 : p0;  // RULE1 RULE5
    return {p[7:3], nib[2:0]};          // RULE2 RULE3
  endfunction

  function automatic logic [7:0] resolve(input wrsag_opreq_s r,
                                         input logic [7:0] p0,
                                         input logic [7:0] p1);
    if (r.short_op || r.field[7:4] == WRSAG_WORK_NIB) begin
      return work_addr(r.field[3:0], p0, p1);  // RULE4
    end
    return r.field;
  endfunction

  // ----------------------------------------------------------------
  // Operand state
  // ----------------------------------------------------------------
  logic [7:0]   base_r;
  logic         pair_r;
  logic         ind_r;
  logic [1:0]   op_ph_r;
  logic [7:0]   hi_r;
  wrsag_state_e st_r;
  wrsag_cmd_e   cmd_r;
  logic [7:0]   res_addr;
  logic         op_go;

  assign res_addr = resolve(op_req, slice_pointer_zero_r, slice_pointer_one_r);
  assign op_go    = op_req.valid && op_ph_r == 2'd0 && st_r == WRSAG_S_IDLE &&
                    (op_req.mode == WRSAG_M_REG || op_req.mode == WRSAG_M_IREG);

  // Slice pointers: reset to the common working area
  always_ff @(posedge clock) begin
    if (reset) begin
      slice_pointer_zero_r <= WRSAG_SP0_RST;  // RULE17
      slice_pointer_one_r  <= WRSAG_SP1_RST;  // RULE17
    end else if (ptr_set && !ptr_set_sel) begin
      slice_pointer_zero_r <= ptr_set_data;
    end else if (ptr_set) begin
      slice_pointer_one_r <= ptr_set_data;
    end
  end

  // Operand read: phase 1 reads MSB (even), phase 2 reads LSB (odd)
  always_ff @(posedge clock) begin
    if (reset) begin
      op_ph_r     <= 2'd0;
      op_done_r   <= 1'b0;
      op_reject_r <= 1'b0;
      op_addr_r   <= 16'h0000;
      op_value_r  <= 16'h0000;
      base_r      <= 8'h00;
      pair_r      <= 1'b0;
      ind_r       <= 1'b0;
      hi_r        <= 8'h00;
    end else begin
      op_done_r   <= 1'b0;
      op_reject_r <= 1'b0;
      if (op_req.valid && op_ph_r == 2'd0 && st_r == WRSAG_S_IDLE && !op_go) begin
        op_reject_r <= 1'b1;  // Modes outside this block are refused; RULE16
      end
      if (op_go) begin
        base_r  <= op_req.pair ? {res_addr[7:1], 1'b0} : res_addr;  // RULE18
        pair_r  <= op_req.pair;
        ind_r   <= op_req.mode == WRSAG_M_IREG;
        op_ph_r <= 2'd1;
      end else if (op_ph_r == 2'd1) begin
        hi_r    <= rf_rdata;
        op_ph_r <= pair_r ? 2'd2 : 2'd3;
      end else if (op_ph_r != 2'd0) begin
        op_ph_r   <= 2'd0;
        op_done_r <= 1'b1;
        if (ind_r) begin
          op_addr_r <= pair_r ? {hi_r, rf_rdata} : {8'h00, hi_r};  // RULE14
          // Byte pointers never reach set 1 upper area
          op_reject_r <= !pair_r && hi_r[7:6] == WRSAG_SET1_TOP;  // RULE15
        end else begin
          op_addr_r  <= {8'h00, base_r};
          op_value_r <= pair_r ? {hi_r, rf_rdata} : {8'h00, hi_r};  // RULE13
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack sequencer
  // ----------------------------------------------------------------
  logic [1:0]  nbytes;
  logic        is_push;
  logic [7:0]  push_byte;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;

  assign sp_dec  = stack_pointer_word_r - 16'h0001;  // RULE11
  assign sp_inc  = stack_pointer_word_r + 16'h0001;  // RULE11
  assign is_push = cmd_r == WRSAG_C_PUSH || cmd_r == WRSAG_C_CALL || cmd_r == WRSAG_C_INT;
  assign nbytes  = (cmd_r == WRSAG_C_INT || cmd_r == WRSAG_C_INT_EXIT) ? 2'd3 :
                   (cmd_r == WRSAG_C_CALL || cmd_r == WRSAG_C_SUB_EXIT) ? 2'd2 : 2'd1;

  // Push order: PC low, PC high, then flags; pops mirror it
  always_comb begin
    push_byte = stk_data;
    if (cmd_r == WRSAG_C_CALL || cmd_r == WRSAG_C_INT) begin
      unique case (st_r)
        WRSAG_S_B0: push_byte = stk_pc[7:0];   // RULE6 RULE7
        WRSAG_S_B1: push_byte = stk_pc[15:8];  // RULE6 RULE7
        WRSAG_S_B2: push_byte = stk_flags;     // RULE7
        WRSAG_S_IDLE: push_byte = stk_data;
      endcase
    end
  end

  // Stack pointer word: no reset on purpose, software must load it
  always_ff @(posedge clock) begin
    if (sp_hi_set) begin
      stack_pointer_word_r[15:8] <= sp_set_data;  // RULE9 RULE10
    end else if (st_r != WRSAG_S_IDLE && is_push) begin
      stack_pointer_word_r[15:8] <= sp_dec[15:8];  // RULE8
    end else if (rf_req_r.rd && st_r != WRSAG_S_IDLE) begin
      stack_pointer_word_r[15:8] <= sp_inc[15:8];  // RULE8
    end
    if (sp_lo_set) begin
      stack_pointer_word_r[7:0] <= sp_set_data;  // RULE9 RULE10
    end else if (st_r != WRSAG_S_IDLE && is_push) begin
      stack_pointer_word_r[7:0] <= sp_dec[7:0];  // RULE8
    end else if (rf_req_r.rd && st_r != WRSAG_S_IDLE) begin
      stack_pointer_word_r[7:0] <= sp_inc[7:0];  // RULE8
    end
  end

  // Step through the bytes; pops need a read then a capture cycle
  logic rd_wait_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      st_r        <= WRSAG_S_IDLE;
      cmd_r       <= WRSAG_C_NONE;
      stk_busy_r  <= 1'b0;
      stk_done_r  <= 1'b0;
      rd_wait_r   <= 1'b0;
      pc_out_r    <= 16'h0000;
      flags_out_r <= 8'h00;
      pop_data_r  <= 8'h00;
    end else begin
      stk_done_r <= 1'b0;
      if (st_r == WRSAG_S_IDLE) begin
        if (stk_cmd != WRSAG_C_NONE && op_ph_r == 2'd0) begin
          cmd_r      <= stk_cmd;
          st_r       <= WRSAG_S_B0;
          stk_busy_r <= 1'b1;
        end
      end else if (!is_push && !rd_wait_r) begin
        rd_wait_r <= 1'b1;
      end else begin
        rd_wait_r <= 1'b0;
        if (!is_push) begin
          unique case (st_r)
            WRSAG_S_B0: begin
              if (cmd_r == WRSAG_C_INT_EXIT) flags_out_r <= rf_rdata;  // RULE7
              else if (cmd_r == WRSAG_C_POP) pop_data_r <= rf_rdata;
              else pc_out_r[15:8] <= rf_rdata;  // RULE6
            end
            WRSAG_S_B1: begin
              if (cmd_r == WRSAG_C_INT_EXIT) pc_out_r[15:8] <= rf_rdata;  // RULE7
              else pc_out_r[7:0] <= rf_rdata;  // RULE6
            end
            WRSAG_S_B2: pc_out_r[7:0] <= rf_rdata;  // RULE7
            WRSAG_S_IDLE: pop_data_r <= pop_data_r;
          endcase
        end
        if ((st_r == WRSAG_S_B0 && nbytes == 2'd1) || (st_r == WRSAG_S_B1 && nbytes == 2'd2) ||
            st_r == WRSAG_S_B2) begin
          st_r       <= WRSAG_S_IDLE;
          stk_busy_r <= 1'b0;
          stk_done_r <= 1'b1;
        end else begin
          st_r <= st_r == WRSAG_S_B0 ? WRSAG_S_B1 : WRSAG_S_B2;
        end
      end
    end
  end

  // Register file port: operand reads, push writes, pop reads
  always_ff @(posedge clock) begin
    if (reset) begin
      rf_req_r <= '0;
    end else begin
      rf_req_r <= '0;
      if (op_go) begin
        rf_req_r.rd   <= 1'b1;
        rf_req_r.addr <= op_req.pair ? {res_addr[7:1], 1'b0} : res_addr;
      end else if (op_ph_r == 2'd1 && pair_r) begin
        rf_req_r.rd   <= 1'b1;
        rf_req_r.addr <= base_r | 8'h01;  // RULE18
      end else if (st_r != WRSAG_S_IDLE && is_push) begin
        rf_req_r.wr    <= 1'b1;
        rf_req_r.addr  <= sp_dec[7:0];  // RULE8
        rf_req_r.wdata <= push_byte;
      end else if (st_r != WRSAG_S_IDLE && !rd_wait_r) begin
        rf_req_r.rd   <= 1'b1;
        rf_req_r.addr <= stack_pointer_word_r[7:0];  // RULE8
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Slice pointers must land on the common area after every reset
  property p_reset_ptrs;
    @(posedge clock) reset |=> slice_pointer_zero_r == WRSAG_SP0_RST &&
                               slice_pointer_one_r == WRSAG_SP1_RST;
  endproperty
  a_reset_ptrs: assert property (p_reset_ptrs) else $error("pointer reset wrong"); // RULE17

  property p_short_addr;
    @(posedge clock) disable iff (reset)
      op_go && op_req.short_op && !op_req.pair |=>
      rf_req_r.addr == {$past(op_req.field[3]) ? $past(slice_pointer_one_r[7:3]) :
                        $past(slice_pointer_zero_r[7:3]), $past(op_req.field[2:0])};
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("short address wrong"); // RULE1

  property p_push_dec;
    @(posedge clock) disable iff (reset || sp_lo_set || sp_hi_set)
      rf_req_r.wr && stk_busy_r |-> rf_req_r.addr == stack_pointer_word_r[7:0];
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push not predecremented"); // RULE8

  // A pop read moves the pointer up by exactly one, carry into the high byte included
  property p_pop_inc;
    @(posedge clock) disable iff (reset)
      rf_req_r.rd && st_r != WRSAG_S_IDLE && !sp_lo_set && !sp_hi_set |=>
      stack_pointer_word_r == $past(stack_pointer_word_r) + 16'h0001;
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("pop not postincremented"); // RULE8

  // A pair read always starts at the even location, which holds the high byte
  property p_pair_even;
    @(posedge clock) disable iff (reset)
      op_go && op_req.pair |=> rf_req_r.rd && !rf_req_r.addr[0];
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("pair start not even"); // RULE18

  property p_call_len;
    @(posedge clock) disable iff (reset)
      st_r == WRSAG_S_IDLE && stk_cmd == WRSAG_C_CALL && op_ph_r == 2'd0 |-> ##3 stk_done_r;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong"); // RULE6

  property p_ind_set1;
    @(posedge clock) disable iff (reset)
      op_done_r && ind_r && !pair_r && op_addr_r[7:6] == WRSAG_SET1_TOP |-> op_reject_r;
  endproperty
  a_ind_set1: assert property (p_ind_set1) else $error("set1 indirect allowed"); // RULE15

  // Main scenarios the bench is expected to reach
  c_call: cover property (@(posedge clock) stk_cmd == WRSAG_C_CALL ##[1:4] stk_done_r);
  c_int_exit: cover property (@(posedge clock) stk_cmd == WRSAG_C_INT_EXIT ##[1:8] stk_done_r);
  c_pop: cover property (@(posedge clock) stk_cmd == WRSAG_C_POP ##[1:4] stk_done_r);
  c_pair: cover property (@(posedge clock) op_go && op_req.pair ##3 op_done_r);
endmodule

// ===== tb/wrsag_rf_model.sv
// Register file model that answers the core's read and write pulses
`timescale 1ns/100ps
module wrsag_rf_model
  import wrsag_pkg::*;
(
  input  wire logic         clock,
  input  wire wrsag_rfreq_s rf_req,
  output logic [7:0]        rf_rdata
);
  logic [7:0] mem [0:255];

  // Known contents, so the bench can predict every read
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // Writes land on the edge that samples the write strobe
  always @(posedge clock) begin
    if (rf_req.wr) begin
      mem[rf_req.addr] <= rf_req.wdata;
    end
  end

  // Read data stands only while the read strobe is up, as the core captures it at
  // the edge that ends that cycle; otherwise the inverse shows, never a stale match
  assign rf_rdata = rf_req.rd ? mem[rf_req.addr] : ~mem[rf_req.addr];
endmodule

// ===== tb/tb_working_reg_stack_addr_gen.sv
// Self-checking bench for the working register and stack address generator
`timescale 1ns/100ps
module tb_working_reg_stack_addr_gen;
  import wrsag_pkg::*;
  logic         clock, reset, sp_lo_set, sp_hi_set, ptr_set, ptr_set_sel;
  logic         op_done_r, op_reject_r, stk_busy_r, stk_done_r, got_done, got_rej;
  logic [7:0]   sp_set_data, ptr_set_data, stk_flags, stk_data, rf_rdata;
  logic [7:0]   flags_out_r, pop_data_r, sl0_r, sl1_r;
  logic [15:0]  stk_pc, op_addr_r, op_value_r, pc_out_r, sp_word, got_addr, got_val;
  wrsag_opreq_s op_req;
  wrsag_rfreq_s rf_req;
  wrsag_cmd_e   stk_cmd;
  int           n_errors, check_count;

  wrsag_core DUT (.clock(clock), .reset(reset), .op_req(op_req), .sp_lo_set(sp_lo_set),
    .sp_hi_set(sp_hi_set), .sp_set_data(sp_set_data), .ptr_set(ptr_set),
    .ptr_set_data(ptr_set_data), .ptr_set_sel(ptr_set_sel), .stk_cmd(stk_cmd),
    .stk_pc(stk_pc), .stk_flags(stk_flags), .stk_data(stk_data), .rf_rdata(rf_rdata),
    .rf_req_r(rf_req), .op_done_r(op_done_r), .op_addr_r(op_addr_r),
    .op_value_r(op_value_r), .op_reject_r(op_reject_r), .stk_busy_r(stk_busy_r),
    .stk_done_r(stk_done_r), .pc_out_r(pc_out_r), .flags_out_r(flags_out_r),
    .pop_data_r(pop_data_r), .stack_pointer_word_r(sp_word),
    .slice_pointer_zero_r(sl0_r), .slice_pointer_one_r(sl1_r));
  wrsag_rf_model rf_model (.clock(clock), .rf_req(rf_req), .rf_rdata(rf_rdata));

  // 20 MHz core clock
  always #25 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Request held until done or refusal; one idle edge follows so valid never re-rises at once
  task automatic op_run(input wrsag_mode_e m, input logic s, input logic p, input logic [7:0] f);
    int n;
    op_req = '{1'b1, m, s, p, f};
    got_done = 1'b0;
    got_rej = 1'b0;
    for (n = 0; n < 10 && !got_done && !got_rej; n++) begin
      step();
      got_done = (op_done_r === 1'b1);
      got_rej = (op_reject_r === 1'b1);
    end
    got_addr = op_addr_r;
    got_val = op_value_r;
    op_req = '0;
    chk({15'h0000, got_done | got_rej}, 16'h0001);
    step();
  endtask

  // Command dropped right after the take edge, then a bounded wait for done
  task automatic stk_run(input wrsag_cmd_e c);
    int n;
    stk_cmd = c;
    step();
    stk_cmd = WRSAG_C_NONE;
    chk({15'h0000, stk_busy_r}, 16'h0001);
    for (n = 0; n < 12 && stk_done_r !== 1'b1; n++) begin
      step();
    end
    chk({15'h0000, stk_done_r}, 16'h0001);
    chk({15'h0000, stk_busy_r}, 16'h0000);
    step();
  endtask

  task automatic sp_write(input logic [15:0] v);
    sp_hi_set = 1'b1;
    sp_set_data = v[15:8];
    step();
    sp_hi_set = 1'b0;
    sp_lo_set = 1'b1;
    sp_set_data = v[7:0];
    step();
    sp_lo_set = 1'b0;
    step();
  endtask

  task automatic ptr_write(input logic sel, input logic [7:0] v);
    ptr_set = 1'b1;
    ptr_set_sel = sel;
    ptr_set_data = v;
    step();
    ptr_set = 1'b0;
    step();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    reset = 1'b1;
    repeat (2) step();
    reset = 1'b0;
    chk({8'h00, sl0_r}, 16'h00c0);
    chk({8'h00, sl1_r}, 16'h00c8);
    $display("test reset done");
  endtask

  // Every 4-bit and 1100B-prefixed operand, at reset pointers and after repointing
  task automatic t_working();
    logic [7:0] sel;
    logic [7:0] a;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        ptr_write(1'b0, 8'h76);
        ptr_write(1'b1, 8'hab);
      end
      for (int i = 0; i < 16; i++) begin
        sel = i[3] ? (k ? 8'hab : 8'hc8) : (k ? 8'h76 : 8'hc0);
        a = {sel[7:3], i[2:0]};
        op_run(WRSAG_M_REG, 1'b1, 1'b0, {4'h0, i[3:0]});
        chk(got_addr, {8'h00, a});
        chk({8'h00, got_val[7:0]}, {8'h00, pat(a)});
        op_run(WRSAG_M_REG, 1'b0, 1'b0, {WRSAG_WORK_NIB, i[3:0]});
        chk(got_addr, {8'h00, a});
      end
    end
    op_run(WRSAG_M_REG, 1'b0, 1'b0, 8'h45);
    chk({8'h00, got_val[7:0]}, {8'h00, pat(8'h45)});
    $display("test working done");
  endtask

  // Pairs, indirect pointers, the set-1 boundary and the modes left to other logic
  task automatic t_pairs_ind();
    op_run(WRSAG_M_REG, 1'b0, 1'b1, 8'h20);
    chk(got_val, {pat(8'h20), pat(8'h21)});
    op_run(WRSAG_M_IREG, 1'b0, 1'b0, 8'h30);
    chk({8'h00, got_addr[7:0]}, {8'h00, pat(8'h30)});
    op_run(WRSAG_M_IREG, 1'b0, 1'b1, 8'h40);
    chk(got_addr, {pat(8'h40), pat(8'h41)});
    op_run(WRSAG_M_IREG, 1'b0, 1'b0, 8'he5);
    chk({14'h0000, got_done, got_rej}, 16'h0002);
    op_run(WRSAG_M_IREG, 1'b0, 1'b0, 8'h9a);
    chk({14'h0000, got_done, got_rej}, 16'h0003);
    op_run(WRSAG_M_IREG, 1'b0, 1'b0, 8'ha5);
    chk({14'h0000, got_done, got_rej}, 16'h0003);
    for (int m = 2; m < 7; m++) begin
      op_run(wrsag_mode_e'(3'(m)), 1'b0, 1'b0, 8'h10);
      chk({14'h0000, got_done, got_rej}, 16'h0001);
    end
    $display("test pairs and indirect done");
  endtask

  // Stack pointer is written before use: its reset value is never relied on
  task automatic t_stack();
    sp_write(16'h0100);
    chk(sp_word, 16'h0100);
    stk_data = 8'h3c;
    stk_run(WRSAG_C_PUSH);
    chk(sp_word, 16'h00ff);
    chk({8'h00, rf_model.mem[8'hff]}, 16'h003c);
    stk_run(WRSAG_C_POP);
    chk({8'h00, pop_data_r}, 16'h003c);
    chk(sp_word, 16'h0100);
    sp_write(16'h00ff);
    stk_pc = 16'h1234;
    stk_run(WRSAG_C_CALL);
    chk(sp_word, 16'h00fd);
    chk({rf_model.mem[8'hfd], rf_model.mem[8'hfe]}, 16'h1234);
    stk_pc = 16'h0000;
    stk_run(WRSAG_C_SUB_EXIT);
    chk(pc_out_r, 16'h1234);
    chk(sp_word, 16'h00ff);
    stk_pc = 16'habcd;
    stk_flags = 8'h5c;
    stk_run(WRSAG_C_INT);
    chk(sp_word, 16'h00fc);
    chk({rf_model.mem[8'hfc], rf_model.mem[8'hfd]}, 16'h5cab);
    chk({8'h00, rf_model.mem[8'hfe]}, 16'h00cd);
    stk_pc = 16'h0000;
    stk_flags = 8'h00;
    stk_run(WRSAG_C_INT_EXIT);
    chk(pc_out_r, 16'habcd);
    chk({8'h00, flags_out_r}, 16'h005c);
    chk(sp_word, 16'h00ff);
    $display("test stack done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence; the last reset proves repointed slices return to the common area
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    op_req = '0;
    {sp_lo_set, sp_hi_set, ptr_set, ptr_set_sel} = 4'h0;
    {sp_set_data, ptr_set_data, stk_flags, stk_data} = 32'h0000_0000;
    stk_pc = 16'h0000;
    stk_cmd = WRSAG_C_NONE;
    n_errors = 0;
    check_count = 0;
    t_reset();
    t_working();
    t_pairs_ind();
    t_stack();
    t_reset();
    close_out();
  end

  // Watchdog: the tests need well under 1500 cycles
  initial begin
    #(50 * 5000);
    n_errors++;
    close_out();
  end
endmodule
